/* hw/cirq_ap_store.sv */
// Active-priority bitmaps of Group 0 and Group 1
`include "cirq_consts.svh"

module cirq_ap_store (
    input wire logic clock, // Core clock
    input wire logic rst_n, // Synchronous reset, active low
    cirq_ap_if.store ap // Write port and read data
);
    logic [31:0] ap0_q;
    logic [31:0] ap1_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ap0_q <= `CIRQ_AP_RESET;
        end else if (ap.wr_en && !ap.grp) begin
            ap0_q <= ap.wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ap1_q <= `CIRQ_AP_RESET;
        end else if (ap.wr_en && ap.grp) begin
            ap1_q <= ap.wr_data;
        end
    end

    assign ap.rd0 = ap0_q;
    assign ap.rd1 = ap1_q;
endmodule

/* hw/cirq_regs.sv */
// Physical interrupt CPU-interface system registers of the core
`include "cirq_consts.svh"

module cirq_regs (
    input wire logic clock, // Core clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic req_valid, // System-register access request
    input wire logic req_write, // 1 write, 0 read
    input wire logic [13:0] req_enc, // Register encoding
    input wire logic [31:0] req_wdata, // Write data
    input wire cirq_pkg::cirq_el_t req_el, // Exception level of access
    input wire logic req_ns, // Access is Non-secure
    input wire logic hcr_virq_route, // Hypervisor routes to guest regs
    input wire logic eoi_valid, // End-of-interrupt write done
    input wire logic eoi_grp, // Group of that write
    input wire logic [7:0] eoi_prio, // Priority being dropped
    input wire logic dir_valid, // Deactivate-register write done
    output logic rsp_valid, // Answer to a request
    output logic [31:0] rsp_rdata, // Read data
    output logic rsp_undef, // Access is undefined and traps
    output logic rsp_to_guest, // Access goes to guest registers
    output logic prio_drop, // Running priority drop pulse
    output logic deactivate, // Interrupt deactivation pulse
    output logic pmr_hint_en, // Priority-mask hint to distributor
    output logic [2:0] grp0_split, // Effective Group 0 split point
    output logic [2:0] grp1_split // Effective Group 1 split point
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] clamp_split(input logic [2:0] v,
                                               input logic [2:0] lo);
        clamp_split = (v < lo) ? lo : v;
    endfunction

    function automatic logic [31:0] prio_bit(input logic [7:0] p);
        prio_bit = 32'h0000_0001 << p[7:3];
    endfunction

    // Common mode reads one step coarser, saturating at the top
    function automatic logic [2:0] next_split(input logic [2:0] v);
        next_split = (v == 3'h7) ? v : v + 3'h1;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cirq_ap_if ap ();
    cirq_pkg::cirq_state_t state_q;
    logic [2:0] bp0_q;
    logic [2:0] bp1_s_q;
    logic [2:0] bp1_ns_q;
    logic priority_mask_hint_enable_q;
    logic eoim_s_q;
    logic eoim_ns_q;
    logic eoim_el3_q;
    logic common_binary_point_s_q;
    logic common_binary_point_ns_q;
    logic rsp_valid_q;
    logic [31:0] rsp_rdata_q;
    logic rsp_undef_q;
    logic rsp_guest_q;
    logic prio_drop_q;
    logic deactivate_q;
    logic [2:0] g0_split_q;
    logic [2:0] g1_split_q;

    cirq_ap_store u_store (
        .clock(clock),
        .rst_n(rst_n),
        .ap(ap.ctrl)
    );

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic take;
    logic guest_ok;
    logic to_guest;
    logic is_el3_reg;
    logic known;
    logic undef;
    logic do_wr;
    logic eoim_cur;
    logic common_binary_point_cur;
    logic [2:0] bp1_cur;
    logic [31:0] ctl1_rd;
    logic [31:0] ctl3_rd;
    logic [31:0] rd_mux;

    // Guest view only from Non-secure EL1 when hypervisor routes there
    assign guest_ok = req_ns && (req_el == cirq_pkg::CIRQ_EL1);
    assign to_guest = hcr_virq_route && guest_ok;
    assign is_el3_reg = (req_enc == `CIRQ_ENC_CTL3);
    assign known = (req_enc == `CIRQ_ENC_AP0) || (req_enc == `CIRQ_ENC_AP1)
        || (req_enc == `CIRQ_ENC_BP0) || (req_enc == `CIRQ_ENC_BP1)
        || (req_enc == `CIRQ_ENC_CTL1) || is_el3_reg;
    // Only the system-register port exists; unknown encodings trap
    assign undef = !known || (req_el == cirq_pkg::CIRQ_EL0)
        || (is_el3_reg && req_el != cirq_pkg::CIRQ_EL3);
    // The answer cycle refuses a request outright
    assign take = req_valid && state_q == cirq_pkg::CIRQ_IDLE;
    assign do_wr = take && req_write && !undef
        && !to_guest;

    // Banked controls of the current security state; EL3 has its own EOI mode
    assign eoim_cur = (req_el == cirq_pkg::CIRQ_EL3) ? eoim_el3_q
        : (req_ns ? eoim_ns_q : eoim_s_q);
    assign common_binary_point_cur = req_ns ? common_binary_point_ns_q : common_binary_point_s_q;
    assign bp1_cur = req_ns ? bp1_ns_q : bp1_s_q;

    // Fixed feature fields with the writable ones merged in
    assign ctl1_rd = `CIRQ_CTL_RO_VALUE
        | ({31'h0, priority_mask_hint_enable_q} << `CIRQ_CTL_PRIORITY_MASK_HINT_ENABLE_BIT)
        | ({31'h0, eoim_cur} << `CIRQ_CTL_EOIM_BIT)
        | ({31'h0, common_binary_point_cur} << `CIRQ_CTL_COMMON_BINARY_POINT_BIT);
    assign ctl3_rd = `CIRQ_CTL_RO_VALUE
        | ({31'h0, 1'b1} << `CIRQ_EL3_NDS_BIT)
        | ({31'h0, priority_mask_hint_enable_q} << `CIRQ_CTL_PRIORITY_MASK_HINT_ENABLE_BIT)
        | ({31'h0, eoim_ns_q} << `CIRQ_EL3_EOI_NS_BIT)
        | ({31'h0, eoim_s_q} << `CIRQ_EL3_EOI_S_BIT)
        | ({31'h0, eoim_el3_q} << `CIRQ_EL3_EOI_EL3_BIT)
        | ({31'h0, common_binary_point_ns_q} << `CIRQ_EL3_COMMON_BINARY_POINT_NS_BIT)
        | ({31'h0, common_binary_point_s_q} << `CIRQ_EL3_COMMON_BINARY_POINT_S_BIT);

    always_comb begin
        case (req_enc)
            `CIRQ_ENC_AP0: rd_mux = ap.rd0;
            `CIRQ_ENC_AP1: rd_mux = ap.rd1;
            `CIRQ_ENC_BP0: rd_mux = {29'h0, bp0_q};
            `CIRQ_ENC_BP1: rd_mux = {29'h0,
                common_binary_point_cur ? clamp_split(next_split(bp0_q), `CIRQ_BP1_NS_MIN)
                         : bp1_cur};
            `CIRQ_ENC_CTL1: rd_mux = ctl1_rd;
            `CIRQ_ENC_CTL3: rd_mux = ctl3_rd;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Request handshake
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= cirq_pkg::CIRQ_IDLE;
        end else begin
            case (state_q)
                cirq_pkg::CIRQ_IDLE: begin
                    if (req_valid) begin
                        state_q <= cirq_pkg::CIRQ_ANSWER;
                    end
                end
                cirq_pkg::CIRQ_ANSWER: state_q <= cirq_pkg::CIRQ_IDLE;
                default: state_q <= cirq_pkg::CIRQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 32'h0000_0000;
            rsp_undef_q <= 1'b0;
            rsp_guest_q <= 1'b0;
        end else begin
            // Refused requests leave no trace in the answer
            rsp_valid_q <= take;
            rsp_undef_q <= take && undef;
            rsp_guest_q <= take && !undef && to_guest;
            rsp_rdata_q <= (take && !req_write && !undef && !to_guest)
                ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Writable state
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bp0_q <= `CIRQ_BP0_MIN;
            bp1_s_q <= `CIRQ_BP1_S_MIN;
            bp1_ns_q <= `CIRQ_BP1_NS_MIN;
        end else if (do_wr && req_enc == `CIRQ_ENC_BP0) begin
            bp0_q <= clamp_split(req_wdata[2:0], `CIRQ_BP0_MIN);
        end else if (do_wr && req_enc == `CIRQ_ENC_BP1 && !common_binary_point_cur) begin
            if (req_ns) begin
                bp1_ns_q <= clamp_split(req_wdata[2:0],
                    `CIRQ_BP1_NS_MIN);
            end else begin
                bp1_s_q <= clamp_split(req_wdata[2:0],
                    `CIRQ_BP1_S_MIN);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            priority_mask_hint_enable_q <= 1'b0;
            eoim_s_q <= 1'b0;
            eoim_ns_q <= 1'b0;
            eoim_el3_q <= 1'b0;
            common_binary_point_s_q <= 1'b0;
            common_binary_point_ns_q <= 1'b0;
        end else if (do_wr && req_enc == `CIRQ_ENC_CTL1) begin
            // Only the writable bits are taken
            priority_mask_hint_enable_q <= req_wdata[`CIRQ_CTL_PRIORITY_MASK_HINT_ENABLE_BIT];
            if (req_el == cirq_pkg::CIRQ_EL3) begin
                eoim_el3_q <= req_wdata[`CIRQ_CTL_EOIM_BIT];
            end else if (req_ns) begin
                eoim_ns_q <= req_wdata[`CIRQ_CTL_EOIM_BIT];
                common_binary_point_ns_q <= req_wdata[`CIRQ_CTL_COMMON_BINARY_POINT_BIT];
            end else begin
                eoim_s_q <= req_wdata[`CIRQ_CTL_EOIM_BIT];
                common_binary_point_s_q <= req_wdata[`CIRQ_CTL_COMMON_BINARY_POINT_BIT];
            end
        end else if (do_wr && is_el3_reg) begin
            priority_mask_hint_enable_q <= req_wdata[`CIRQ_CTL_PRIORITY_MASK_HINT_ENABLE_BIT];
            eoim_ns_q <= req_wdata[`CIRQ_EL3_EOI_NS_BIT];
            eoim_s_q <= req_wdata[`CIRQ_EL3_EOI_S_BIT];
            eoim_el3_q <= req_wdata[`CIRQ_EL3_EOI_EL3_BIT];
            common_binary_point_ns_q <= req_wdata[`CIRQ_EL3_COMMON_BINARY_POINT_NS_BIT];
            common_binary_point_s_q <= req_wdata[`CIRQ_EL3_COMMON_BINARY_POINT_S_BIT];
        end
    end

    // Active maps: software write, or end-of-interrupt clears the bit
    always_comb begin
        ap.wr_en = 1'b0;
        ap.grp = 1'b0;
        ap.wr_data = 32'h0000_0000;
        if (do_wr && req_enc == `CIRQ_ENC_AP0) begin
            ap.wr_en = 1'b1;
            ap.wr_data = req_wdata;
        end else if (do_wr && req_enc == `CIRQ_ENC_AP1) begin
            ap.wr_en = 1'b1;
            ap.grp = 1'b1;
            ap.wr_data = req_wdata;
        // A map write in the same cycle wins over an end-of-interrupt
        end else if (eoi_valid) begin
            ap.wr_en = 1'b1;
            ap.grp = eoi_grp;
            ap.wr_data = (eoi_grp ? ap.rd1 : ap.rd0)
                & ~prio_bit(eoi_prio);
        end
    end

    // ------------------------------------------------------------
    // Distributor side
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prio_drop_q <= 1'b0;
            deactivate_q <= 1'b0;
        end else begin
            prio_drop_q <= eoi_valid;
            // Mode 0 deactivates on end-of-interrupt; deactivate
            // register is then ignored as its effect is unpredictable
            deactivate_q <= eoim_cur ? dir_valid : eoi_valid;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            g0_split_q <= `CIRQ_BP0_MIN;
            g1_split_q <= `CIRQ_BP1_NS_MIN;
        end else begin
            // Group 1 follows the Group 0 split in common mode
            g0_split_q <= bp0_q;
            g1_split_q <= common_binary_point_cur ? bp0_q : bp1_cur;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_rdata_q;
    assign rsp_undef = rsp_undef_q;
    assign rsp_to_guest = rsp_guest_q;
    assign prio_drop = prio_drop_q;
    assign deactivate = deactivate_q;
    assign pmr_hint_en = priority_mask_hint_enable_q;
    assign grp0_split = g0_split_q;
    assign grp1_split = g1_split_q;
endmodule

/* shared/cirq_ap_if.sv */
// Carrier between the control logic and the active-priority store
interface cirq_ap_if;
    logic wr_en;
    logic grp;
    logic [31:0] wr_data;
    logic [31:0] rd0;
    logic [31:0] rd1;
    modport ctrl (output wr_en, grp, wr_data, input rd0, rd1);
    modport store (input wr_en, grp, wr_data, output rd0, rd1);
endinterface

/* shared/cirq_consts.svh */
// Constants of the interrupt CPU-interface register set
`ifndef CIRQ_CONSTS_SVH
`define CIRQ_CONSTS_SVH

// System-register encodings {op1, crn, crm, op2}; op0 is always 3
`define CIRQ_ENC_AP0 14'h0644
`define CIRQ_ENC_AP1 14'h0648
`define CIRQ_ENC_BP0 14'h0643
`define CIRQ_ENC_BP1 14'h0663
`define CIRQ_ENC_CTL1 14'h0664
`define CIRQ_ENC_CTL3 14'h3664

// Control-register fields
`define CIRQ_CTL_HAV_BIT 15
`define CIRQ_CTL_SYS_ERROR_IRQ_SUPPORT_BIT 14
`define CIRQ_CTL_IDW_LSB 11
`define CIRQ_CTL_PRIW_LSB 8
`define CIRQ_CTL_PRIORITY_MASK_HINT_ENABLE_BIT 6
`define CIRQ_CTL_EOIM_BIT 1
`define CIRQ_CTL_COMMON_BINARY_POINT_BIT 0
`define CIRQ_CTL_RO_VALUE 32'h0000_8400
`define CIRQ_EL3_NDS_BIT 17
`define CIRQ_EL3_EOI_NS_BIT 4
`define CIRQ_EL3_EOI_S_BIT 3
`define CIRQ_EL3_EOI_EL3_BIT 2
`define CIRQ_EL3_COMMON_BINARY_POINT_NS_BIT 1
`define CIRQ_EL3_COMMON_BINARY_POINT_S_BIT 0

// Reset values and minimum split points
`define CIRQ_AP_RESET 32'h0000_0000
`define CIRQ_BP0_MIN 3'h2
`define CIRQ_BP1_S_MIN 3'h2
`define CIRQ_BP1_NS_MIN 3'h3

`endif

/* shared/cirq_pkg.sv */
// Types of the interrupt CPU-interface register set
package cirq_pkg;
    typedef enum logic [1:0] {
        CIRQ_EL0,
        CIRQ_EL1,
        CIRQ_EL2,
        CIRQ_EL3
    } cirq_el_t;

    typedef enum {
        CIRQ_IDLE,
        CIRQ_ANSWER
    } cirq_state_t;
endpackage

/* testbench/cirq_dist_model.sv */
// Distributor-side model raising end-of-interrupt and deactivate events
module cirq_dist_model (
    input wire logic clock, // Core clock
    input wire logic prio_drop, // Drop from block
    input wire logic deactivate, // Deactivate from block
    output logic eoi_valid, // End-of-interrupt event
    output logic eoi_grp, // Its group
    output logic [7:0] eoi_prio, // Its priority
    output logic dir_valid, // Deactivate event
    output logic seen_drop, // Drop captured
    output logic seen_deact // Deactivate captured
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        eoi_valid = 1'h0;
        dir_valid = 1'h0;
        eoi_grp = 1'h0;
        eoi_prio = 8'h00;
        seen_drop = 1'h0;
        seen_deact = 1'h0;
    end
    // One-cycle event; qualifiers flip once released
    task automatic send(input logic dir, input logic grp,
                        input logic [7:0] prio);
        @(negedge clock);
        eoi_valid = !dir;
        dir_valid = dir;
        eoi_grp = grp;
        eoi_prio = prio;
        @(negedge clock);
        seen_drop = prio_drop;
        seen_deact = deactivate;
        eoi_valid = 1'h0;
        dir_valid = 1'h0;
        eoi_grp = !grp;
        eoi_prio = ~prio;
    endtask
endmodule

/* testbench/cirq_regs_chk.sv */
// Port checker for the interrupt CPU-interface register block
`include "cirq_consts.svh"

module cirq_regs_chk (
    input wire logic clock, // Core clock
    input wire logic rst_n, // Reset
    input wire logic req_valid, // Request
    input wire logic req_write, // Write
    input wire logic [13:0] req_enc, // Encoding
    input wire cirq_pkg::cirq_el_t req_el, // Level
    input wire logic req_ns, // Non-secure
    input wire logic hcr_virq_route, // Guest route
    input wire logic eoi_valid, // End of interrupt
    input wire logic dir_valid, // Deactivate write
    input wire logic rsp_valid, // Answer
    input wire logic [31:0] rsp_rdata, // Read data
    input wire logic rsp_undef, // Trap
    input wire logic rsp_to_guest, // Guest
    input wire logic prio_drop, // Drop
    input wire logic deactivate, // Deactivate
    input wire logic [2:0] grp0_split, // Split 0
    input wire logic [2:0] grp1_split // Split 1
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic rd_ok;
    assign rd_ok = rsp_valid && !rsp_undef && !rsp_to_guest;

    rsp_single_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer held over one cycle");
    rsp_cause_a: assert property (rsp_valid |-> $past(req_valid))
        else $error("answer without request");
    el0_trap_a: assert property (rsp_valid &&
        $past(req_el) == cirq_pkg::CIRQ_EL0 |-> rsp_undef)
        else $error("lowest level access not trapped");
    ctl_fixed_a: assert property (rd_ok && !$past(req_write) &&
        $past(req_enc) == `CIRQ_ENC_CTL1 |-> rsp_rdata[31:7] ==
        25'h000_0108 && rsp_rdata[5:2] == 4'h0)
        else $error("control fixed bits wrong");
    bp_field_a: assert property (rd_ok && !$past(req_write) &&
        $past(req_enc) == `CIRQ_ENC_BP0 |-> rsp_rdata[31:3] == 29'h0 &&
        rsp_rdata[2:0] >= 3'h2)
        else $error("group 0 split read wrong");
    split_min_a: assert property (grp0_split >= 3'h2)
        else $error("group 0 split below minimum");
    split1_min_a: assert property (grp1_split >= 3'h2)
        else $error("group 1 split below minimum");
    guest_only_a: assert property (rsp_to_guest |->
        $past(req_ns) && $past(hcr_virq_route) &&
        $past(req_el) == cirq_pkg::CIRQ_EL1)
        else $error("guest route outside non-secure level one");
    eoi_drop_a: assert property (eoi_valid |=> prio_drop)
        else $error("no priority drop after end of interrupt");
    drop_src_a: assert property (prio_drop |-> $past(eoi_valid))
        else $error("priority drop without cause");
    deact_src_a: assert property (deactivate |->
        $past(eoi_valid) || $past(dir_valid))
        else $error("deactivation without cause");
endmodule

bind cirq_regs cirq_regs_chk u_chk (.clock, .rst_n, .req_valid,
    .req_write, .req_enc, .req_el, .req_ns, .hcr_virq_route, .eoi_valid,
    .dir_valid, .rsp_valid, .rsp_rdata, .rsp_undef, .rsp_to_guest,
    .prio_drop, .deactivate, .grp0_split, .grp1_split);

/* testbench/cirq_regs_tb_top.sv */
// Self-checking bench of the interrupt CPU-interface register block
`include "cirq_consts.svh"

module cirq_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, req_valid, req_write, req_ns, hcr_virq_route;
    logic [13:0] req_enc;
    logic [31:0] req_wdata, rsp_rdata, rd_v;
    cirq_pkg::cirq_el_t req_el;
    logic eoi_valid, eoi_grp, dir_valid, seen_drop, seen_deact;
    logic [7:0] eoi_prio;
    logic rsp_valid, rsp_undef, rsp_to_guest, prio_drop, deactivate;
    logic pmr_hint_en, und_v, gst_v;
    logic [2:0] grp0_split, grp1_split;
    int fail_count = 0;
    int checked = 0;

    cirq_regs u_dut (.clock, .rst_n, .req_valid, .req_write, .req_enc,
        .req_wdata, .req_el, .req_ns, .hcr_virq_route, .eoi_valid,
        .eoi_grp, .eoi_prio, .dir_valid, .rsp_valid, .rsp_rdata,
        .rsp_undef, .rsp_to_guest, .prio_drop, .deactivate, .pmr_hint_en,
        .grp0_split, .grp1_split);
    cirq_dist_model u_dist (.clock, .prio_drop, .deactivate, .eoi_valid,
        .eoi_grp, .eoi_prio, .dir_valid, .seen_drop, .seen_deact);

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [13:0] enc,
                       input logic [31:0] wd);
        @(negedge clock);
        req_valid = 1'h1;
        req_write = wr;
        req_enc = enc;
        req_wdata = wd;
        @(negedge clock);
        req_valid = 1'h0;
        check(rsp_valid, 1'h1);
        rd_v = rsp_rdata;
        und_v = rsp_undef;
        gst_v = rsp_to_guest;
    endtask
    task automatic rd(input logic [13:0] enc, input logic [31:0] exp);
        acc(1'h0, enc, 32'h0000_0000);
        check(rd_v, exp);
    endtask
    // Control is banked, so both copies get the same value
    task automatic ctl(input logic [31:0] v);
        req_ns = 1'h0;
        acc(1'h1, `CIRQ_ENC_CTL1, v);
        req_ns = 1'h1;
        acc(1'h1, `CIRQ_ENC_CTL1, v);
    endtask
    task automatic final_report();
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        final_report();
    end
    initial begin
        {rst_n, req_valid, req_write, hcr_virq_route} = 4'h0;
        req_ns = 1'h1;
        req_enc = 14'h0000;
        req_wdata = 32'h0000_0000;
        req_el = cirq_pkg::CIRQ_EL1;
        repeat (16) @(negedge clock);
        rst_n = 1'h1;
        check(grp0_split, 3'h2);
        check(grp1_split, 3'h3);
        check(pmr_hint_en, 1'h0);
        rd(`CIRQ_ENC_AP0, 32'h0000_0000);
        rd(`CIRQ_ENC_AP1, 32'h0000_0000);
        acc(1'h1, `CIRQ_ENC_AP0, 32'h8000_0001);
        rd(`CIRQ_ENC_AP0, 32'h8000_0001);
        acc(1'h1, `CIRQ_ENC_AP1, 32'h8000_0000);
        rd(`CIRQ_ENC_AP1, 32'h8000_0000);
        rd(`CIRQ_ENC_CTL1, 32'h0000_8400);
        acc(1'h1, `CIRQ_ENC_BP0, 32'h0000_0000);
        rd(`CIRQ_ENC_BP0, 32'h0000_0002);
        acc(1'h1, `CIRQ_ENC_BP0, 32'hFFFF_FFFD);
        rd(`CIRQ_ENC_BP0, 32'h0000_0005);
        check(grp0_split, 3'h5);
        acc(1'h1, `CIRQ_ENC_BP1, 32'h0000_0000);
        rd(`CIRQ_ENC_BP1, 32'h0000_0003);
        check(grp1_split, 3'h3);
        req_ns = 1'h0;
        acc(1'h1, `CIRQ_ENC_BP1, 32'h0000_0000);
        rd(`CIRQ_ENC_BP1, 32'h0000_0002);
        req_ns = 1'h1;
        acc(1'h1, `CIRQ_ENC_AP0, 32'h0000_0004);
        u_dist.send(1'h0, 1'h0, 8'h10);
        check(seen_drop, 1'h1);
        check(seen_deact, 1'h1);
        rd(`CIRQ_ENC_AP0, 32'h0000_0000);
        u_dist.send(1'h1, 1'h0, 8'h00);
        check(seen_deact, 1'h0);
        ctl(32'hFFFF_FFFF);
        rd(`CIRQ_ENC_CTL1, 32'h0000_8443);
        check(pmr_hint_en, 1'h1);
        check(grp1_split, 3'h5);
        u_dist.send(1'h0, 1'h1, 8'h00);
        check(seen_drop, 1'h1);
        check(seen_deact, 1'h0);
        u_dist.send(1'h1, 1'h0, 8'h00);
        check(seen_deact, 1'h1);
        ctl(32'h0000_0000);
        check(pmr_hint_en, 1'h0);
        acc(1'h0, `CIRQ_ENC_CTL3, 32'h0000_0000);
        check(und_v, 1'h1);
        acc(1'h0, 14'h0000, 32'h0000_0000);
        check(und_v, 1'h1);
        req_el = cirq_pkg::CIRQ_EL3;
        acc(1'h1, `CIRQ_ENC_CTL3, 32'h0000_0014);
        rd(`CIRQ_ENC_CTL3, 32'h0002_8414);
        rd(`CIRQ_ENC_CTL1, 32'h0000_8402);
        req_el = cirq_pkg::CIRQ_EL1;
        req_ns = 1'h0;
        rd(`CIRQ_ENC_CTL1, 32'h0000_8400);
        req_ns = 1'h1;
        rd(`CIRQ_ENC_CTL1, 32'h0000_8402);
        req_el = cirq_pkg::CIRQ_EL0;
        acc(1'h0, `CIRQ_ENC_AP0, 32'h0000_0000);
        check(und_v, 1'h1);
        req_el = cirq_pkg::CIRQ_EL1;
        hcr_virq_route = 1'h1;
        acc(1'h0, `CIRQ_ENC_BP0, 32'h0000_0000);
        check(gst_v, 1'h1);
        req_ns = 1'h0;
        acc(1'h0, `CIRQ_ENC_BP0, 32'h0000_0000);
        check(gst_v, 1'h0);
        final_report();
    end
endmodule
